// ---- rtl/srrc_pkg.sv ----
package srrc_pkg;
    // ==========================================================
    // Register map (byte addresses, AXI4-Lite)
    localparam logic [7:0]  ADDR_WDOG     = 8'h00;
    localparam logic [7:0]  ADDR_STBY     = 8'h04;
    localparam logic [7:0]  ADDR_CPU      = 8'h08;
    localparam logic [7:0]  ADDR_STATUS   = 8'h0C;
    localparam logic [7:0]  ADDR_RSTVAL0  = 8'h10;
    localparam logic [7:0]  ADDR_RSTVAL1  = 8'h14;
    localparam logic [7:0]  ADDR_RESETVEC = 8'h18;
    // ==========================================================
    // Field positions
    localparam int WDOG_PRIO_BIT = 4;
    localparam int STBY_STOP_BIT = 1;
    localparam logic [7:0] WDOG_WMASK = 8'h9E;
    // ==========================================================
    // Reset values
    localparam logic [15:0] WAIT_CTRL_RST   = 16'hC0AA;
    localparam logic [7:0]  ASYNC_MODE_RST  = 8'h80;
    localparam logic [7:0]  ASYNC_STAT_RST  = 8'h00;
    localparam logic [7:0]  MASK_BYTE_RST   = 8'hFF;
    localparam logic [15:0] MASK_WORD_RST   = 16'hFFFF;
    localparam logic [15:0] PSTAT_RST       = 16'h0000;
    localparam logic [15:0] RESET_VEC_ADDR0 = 16'h0000;
    localparam logic [15:0] RESET_VEC_ADDR1 = 16'h0001;
    localparam logic [7:0]  WDOG_RST        = 8'h00;
    // ==========================================================
    // Context recorded at standby entry
    typedef enum logic [1:0] {
        SRRC_CTX_NONE = 2'b00,
        SRRC_CTX_WDT  = 2'b01,
        SRRC_CTX_NMI  = 2'b10
    } srrc_ctx_t;
    // Sequencer states
    typedef enum logic [2:0] {
        SRRC_RUN    = 3'b000,
        SRRC_STOP   = 3'b001,
        SRRC_NMIHLD = 3'b010,
        SRRC_STAB   = 3'b011,
        SRRC_RESET  = 3'b100
    } srrc_state_t;
    // Resume actions
    typedef enum logic [1:0] {
        SRRC_RES_NEXT   = 2'b00,
        SRRC_RES_VECTOR = 2'b01,
        SRRC_RES_RESET  = 2'b10
    } srrc_resume_t;
endpackage : srrc_pkg

// ---- rtl/srrc_top.sv ----
module srrc_top
    import srrc_pkg::*;
#(
    parameter int WDT_BITS = 8     // Stabilisation count width, counter has one extra overflow bit
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        clk_en,
    input  wire logic        ext_reset_n,       // External reset pin level
    input  wire logic        nmi_pin,           // NMI pin level, active high
    input  wire logic        cpu_in_wdt_isr,    // Core is inside watchdog routine
    input  wire logic        cpu_in_nmi_isr,    // Core is inside NMI routine
    input  wire logic        cpu_insn_done,     // Core retired one instruction
    input  wire logic        cpu_return_from_irq, // Core executed return_from_irq
    input  wire logic        wdt_irq_req,       // Watchdog overflow request
    input  wire logic [15:0] reset_vec_word,    // Word read from reset vector
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             osc_run,           // Oscillator enable
    output logic             sys_clk_run,       // Internal system clock gate
    output logic             unit_reset,        // Hold all units in reset
    output logic             pins_hiz,          // Signal pins high impedance
    output logic             pc_load,           // Load program counter, pulse
    output logic [15:0]      pc_value,          // Value for program counter
    output logic             nmi_vector,        // Take NMI vector, pulse
    output logic             wdt_vector,        // Take watchdog vector, pulse
    output logic             keep_ram_sp,       // Retain RAM and stack pointer
    output logic [15:0]      wait_ctrl_reg,
    output logic [15:0]      program_status_word,
    output logic [7:0]       async_serial_mode_reg,
    output logic [7:0]       async_serial_status_reg,
    output logic [7:0]       irq_mask_low,
    output logic [7:0]       irq_mask_high,
    output logic [15:0]      irq_mask_word
);
    import srrc_pkg::*;

    // Elaboration check: the overflow bit must exist and the count stay short
    if (WDT_BITS < 2 || WDT_BITS > 16) begin : g_bad_wdt_bits
        $error("WDT_BITS out of range");
    end

    // ==========================================================
    // State registers
    srrc_state_t       state_reg, state_next;
    srrc_ctx_t         ctx_reg, ctx_next;           // Context at stop entry
    logic [7:0]        watchdog_mode_reg, watchdog_mode_next; // Mode and priority
    logic [7:0]        standby_ctrl_reg, standby_ctrl_next;   // Stop request
    logic [WDT_BITS:0] wdt_reg, wdt_next;           // Stabilisation counter
    logic              from_stop_reg, from_stop_next; // Reset ended standby
    logic              nmi_pend_reg, nmi_pend_next; // NMI held pending
    logic              arm_reg, arm_next;           // Pending NMI armed by return
    logic              one_nmi_reg, one_nmi_next;   // One NMI instruction then WDT
    logic              nmi_prev_reg, nmi_prev_next; // NMI edge detect
    logic              rst_prev_reg, rst_prev_next; // Reset edge detect
    logic              aw_reg, aw_next;
    logic              w_reg, w_next;
    logic [7:0]        awa_reg, awa_next;
    logic [31:0]       wd_reg, wd_next;
    logic [3:0]        ws_reg, ws_next;
    logic              bv_reg, bv_next;
    logic              bad_reg, bad_next;
    logic              rv_reg, rv_next;
    logic [31:0]       rd_reg, rd_next;
    logic              rbad_reg, rbad_next;
    logic              nmi_vec_next, wdt_vec_next, pc_load_next;

    logic              prio;
    logic              nmi_edge;
    logic              wr_fire;

    assign prio     = watchdog_mode_reg[WDOG_PRIO_BIT];
    assign nmi_edge = nmi_pin && !nmi_prev_reg;
    assign wr_fire  = aw_reg && w_reg && !bv_reg;

    // Handshake outputs are combinational off the capture flags
    assign s_axi_awready = !aw_reg;
    assign s_axi_wready  = !w_reg;
    assign s_axi_arready = !rv_reg;
    assign s_axi_bvalid  = bv_reg;
    assign s_axi_bresp   = bad_reg ? 2'b10 : 2'b00;
    assign s_axi_rvalid  = rv_reg;
    assign s_axi_rdata   = rd_reg;
    assign s_axi_rresp   = rbad_reg ? 2'b10 : 2'b00;

    assign unit_reset  = (state_reg == SRRC_RESET);
    assign pins_hiz    = (state_reg == SRRC_RESET);
    assign osc_run     = (state_reg != SRRC_STOP);
    assign sys_clk_run = (state_reg == SRRC_RUN);
    assign keep_ram_sp = from_stop_reg;
    assign pc_value    = reset_vec_word;

    // Reset-time loads of the fixed registers
    logic [15:0] prog_status_reg;
    assign wait_ctrl_reg           = WAIT_CTRL_RST;
    assign async_serial_mode_reg   = ASYNC_MODE_RST;
    assign async_serial_status_reg = ASYNC_STAT_RST;
    assign irq_mask_low            = MASK_BYTE_RST;
    assign irq_mask_high           = MASK_BYTE_RST;
    assign irq_mask_word           = MASK_WORD_RST;
    assign program_status_word     = prog_status_reg;

    // ==========================================================
    // Sequencer and register file next state
    always_comb begin
        state_next     = state_reg;
        ctx_next       = ctx_reg;
        watchdog_mode_next = watchdog_mode_reg;
        standby_ctrl_next  = standby_ctrl_reg;
        wdt_next       = wdt_reg;
        from_stop_next = from_stop_reg;
        nmi_pend_next  = nmi_pend_reg;
        arm_next       = arm_reg;
        one_nmi_next   = one_nmi_reg;
        nmi_prev_next  = nmi_pin;
        rst_prev_next  = ext_reset_n;
        nmi_vec_next   = 1'b0;
        wdt_vec_next   = 1'b0;
        pc_load_next   = 1'b0;
        aw_next        = aw_reg;
        w_next         = w_reg;
        awa_next       = awa_reg;
        wd_next        = wd_reg;
        ws_next        = ws_reg;
        bv_next        = bv_reg;
        bad_next       = bad_reg;
        rv_next        = rv_reg;
        rd_next        = rd_reg;
        rbad_next      = rbad_reg;

        // Write channels may arrive in either order
        if (s_axi_awvalid && !aw_reg) begin
            aw_next  = 1'b1;
            awa_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_reg) begin
            w_next  = 1'b1;
            wd_next = s_axi_wdata;
            ws_next = s_axi_wstrb;
        end
        if (wr_fire) begin
            bv_next  = 1'b1;
            aw_next  = 1'b0;
            w_next   = 1'b0;
            bad_next = 1'b0;
            case (awa_reg)
                ADDR_WDOG: begin
                    // Fixed-zero bits are dropped on write
                    if (ws_reg[0]) watchdog_mode_next = wd_reg[7:0] & WDOG_WMASK;
                end
                ADDR_STBY: begin
                    if (ws_reg[0]) standby_ctrl_next = wd_reg[7:0];
                end
                ADDR_STATUS, ADDR_CPU, ADDR_RSTVAL0, ADDR_RSTVAL1, ADDR_RESETVEC: begin
                end
                default: bad_next = 1'b1;
            endcase
        end
        if (bv_reg && s_axi_bready) bv_next = 1'b0;

        // Read channel
        if (s_axi_arvalid && !rv_reg) begin
            rv_next   = 1'b1;
            rbad_next = 1'b0;
            case (s_axi_araddr)
                ADDR_WDOG:     rd_next = {24'h00_0000, watchdog_mode_reg};
                ADDR_STBY:     rd_next = {24'h00_0000, standby_ctrl_reg};
                ADDR_CPU:      rd_next = {wait_ctrl_reg, prog_status_reg};
                ADDR_STATUS:   rd_next = {24'h00_0000, 1'b0, nmi_pend_reg, ctx_reg,
                                          from_stop_reg, state_reg};
                ADDR_RSTVAL0:  rd_next = {irq_mask_word, irq_mask_high, irq_mask_low};
                ADDR_RSTVAL1:  rd_next = {16'h0000, async_serial_status_reg,
                                          async_serial_mode_reg};
                ADDR_RESETVEC: rd_next = {RESET_VEC_ADDR1, RESET_VEC_ADDR0};
                default: begin
                    rd_next   = 32'h0000_0000;
                    rbad_next = 1'b1;
                end
            endcase
        end else if (rv_reg && s_axi_rready) begin
            rv_next = 1'b0;
        end

        // Return of the interrupted routine arms the held NMI
        if (cpu_return_from_irq && nmi_pend_reg) arm_next = 1'b1;
        if (arm_reg && cpu_insn_done) begin
            nmi_vec_next  = 1'b1;
            nmi_pend_next = 1'b0;
            arm_next      = 1'b0;
        end
        // Simultaneous watchdog and NMI with watchdog priority
        if (state_reg == SRRC_RUN && wdt_irq_req && nmi_edge && prio) begin
            nmi_vec_next = 1'b1;
            one_nmi_next = 1'b1;
        end
        if (one_nmi_reg && cpu_insn_done) begin
            wdt_vec_next = 1'b1;
            one_nmi_next = 1'b0;
        end

        case (state_reg)
            SRRC_RUN: begin
                if (wr_fire && awa_reg == ADDR_STBY && ws_reg[0]
                    && wd_reg[STBY_STOP_BIT]) begin
                    state_next = SRRC_STOP;
                    // Record the service context
                    if (cpu_in_nmi_isr)      ctx_next = SRRC_CTX_NMI;
                    else if (cpu_in_wdt_isr) ctx_next = SRRC_CTX_WDT;
                    else                     ctx_next = SRRC_CTX_NONE;
                end
            end
            SRRC_STOP: begin
                wdt_next = '0;
                if (nmi_edge) state_next = SRRC_NMIHLD;
            end
            SRRC_NMIHLD: begin
                wdt_next = '0;
                if (!nmi_pin) state_next = SRRC_STAB;
            end
            SRRC_STAB: begin
                wdt_next = wdt_reg + 1'b1;
                if (wdt_reg[WDT_BITS]) begin
                    state_next = SRRC_RUN;
                    standby_ctrl_next[STBY_STOP_BIT] = 1'b0;
                    case (ctx_reg)
                        SRRC_CTX_WDT: begin
                            if (prio) nmi_pend_next = 1'b1;
                            else      nmi_vec_next  = 1'b1;
                        end
                        SRRC_CTX_NMI:  nmi_pend_next = 1'b1;
                        SRRC_CTX_NONE: nmi_vec_next  = 1'b1;
                        default:       nmi_vec_next  = 1'b1;
                    endcase
                end
            end
            SRRC_RESET: begin
                if (ext_reset_n) begin
                    state_next   = SRRC_RUN;
                    pc_load_next = 1'b1;
                end
            end
            default: state_next = SRRC_RESET;
        endcase

        // Reset pin overrides the sequencer, mode, standby and vector logic; AXI handshakes still run
        if (!ext_reset_n) begin
            if (state_reg != SRRC_RESET) begin
                // Falling edge in standby: oscillator restarts now
                from_stop_next = (state_reg != SRRC_RUN) && rst_prev_reg;
            end
            state_next    = SRRC_RESET;
            watchdog_mode_next = WDOG_RST;
            standby_ctrl_next  = 8'h00;
            nmi_pend_next = 1'b0;
            arm_next      = 1'b0;
            one_nmi_next  = 1'b0;
            nmi_vec_next  = 1'b0;
            wdt_vec_next  = 1'b0;
        end
    end

    // ==========================================================
    // Register stage
    logic nmi_vec_reg, wdt_vec_reg, pc_load_reg;
    assign nmi_vector = nmi_vec_reg;
    assign wdt_vector = wdt_vec_reg;
    assign pc_load    = pc_load_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg     <= SRRC_RESET;
            ctx_reg       <= SRRC_CTX_NONE;
            watchdog_mode_reg <= WDOG_RST;
            standby_ctrl_reg  <= 8'h00;
            wdt_reg       <= '0;
            from_stop_reg <= 1'b0;
            nmi_pend_reg  <= 1'b0;
            arm_reg       <= 1'b0;
            one_nmi_reg   <= 1'b0;
            nmi_prev_reg  <= 1'b0;
            rst_prev_reg  <= 1'b1;
            aw_reg        <= 1'b0;
            w_reg         <= 1'b0;
            awa_reg       <= 8'h00;
            wd_reg        <= 32'h0000_0000;
            ws_reg        <= 4'h0;
            bv_reg        <= 1'b0;
            bad_reg       <= 1'b0;
            rv_reg        <= 1'b0;
            rd_reg        <= 32'h0000_0000;
            rbad_reg      <= 1'b0;
            nmi_vec_reg   <= 1'b0;
            wdt_vec_reg   <= 1'b0;
            pc_load_reg   <= 1'b0;
            prog_status_reg <= PSTAT_RST;
        end else if (clk_en) begin
            state_reg     <= state_next;
            ctx_reg       <= ctx_next;
            watchdog_mode_reg <= watchdog_mode_next;
            standby_ctrl_reg  <= standby_ctrl_next;
            wdt_reg       <= wdt_next;
            from_stop_reg <= from_stop_next;
            nmi_pend_reg  <= nmi_pend_next;
            arm_reg       <= arm_next;
            one_nmi_reg   <= one_nmi_next;
            nmi_prev_reg  <= nmi_prev_next;
            rst_prev_reg  <= rst_prev_next;
            aw_reg        <= aw_next;
            w_reg         <= w_next;
            awa_reg       <= awa_next;
            wd_reg        <= wd_next;
            ws_reg        <= ws_next;
            bv_reg        <= bv_next;
            bad_reg       <= bad_next;
            rv_reg        <= rv_next;
            rd_reg        <= rd_next;
            rbad_reg      <= rbad_next;
            nmi_vec_reg   <= nmi_vec_next;
            wdt_vec_reg   <= wdt_vec_next;
            pc_load_reg   <= pc_load_next;
            // Status word cleared by any reset that did not end standby
            if (!ext_reset_n && !from_stop_next) prog_status_reg <= PSTAT_RST;
        end
    end

    // ==========================================================
    // Checks
    chk_wdog_zero_bits: assert property (@(posedge aclk) disable iff (!aresetn)
        (watchdog_mode_reg & 8'h61) == 8'h00) else $error("fixed-zero watchdog bits set");
    chk_reset_hiz: assert property (@(posedge aclk) disable iff (!aresetn)
        unit_reset |-> pins_hiz && !sys_clk_run) else $error("pins driven in reset");
    chk_stop_entry: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && ext_reset_n && state_reg == SRRC_RUN && wr_fire && awa_reg == ADDR_STBY
        && ws_reg[0] && wd_reg[STBY_STOP_BIT] |=> state_reg == SRRC_STOP)
        else $error("stop not entered");
    chk_hold_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        state_reg == SRRC_NMIHLD |=> wdt_reg == '0) else $error("counter ran during NMI");
    chk_clk_after_ovf: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(sys_clk_run) |-> $past(state_reg) == SRRC_STAB || $past(state_reg) == SRRC_RESET)
        else $error("clock restarted early");
    chk_reset_enter: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && !ext_reset_n |=> state_reg == SRRC_RESET && osc_run)
        else $error("reset not entered");
    chk_pc_load: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && state_reg == SRRC_RESET && ext_reset_n |=> pc_load)
        else $error("vector not loaded");
    chk_one_nmi_insn: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && one_nmi_reg && cpu_insn_done && ext_reset_n |=> wdt_vector)
        else $error("watchdog routine not entered");
    chk_wait_reset: assert property (@(posedge aclk) disable iff (!aresetn)
        wait_ctrl_reg == 16'hC0AA && irq_mask_word == 16'hFFFF)
        else $error("reset values wrong");
endmodule : srrc_top

// ---- bench/srrc_ext_src.sv ----
// ==========================================================
// External reset pin and NMI pin sources
module srrc_ext_src #(
    parameter int MIN_RST = 8          // Shortest reset pulse, covers stabilisation count
) (
    input  wire logic       aclk,
    input  wire logic       nmi_go,    // Start an NMI pulse
    input  wire logic [7:0] nmi_len,   // NMI active cycles
    input  wire logic       rst_go,    // Start a reset pulse
    input  wire logic [7:0] rst_len,   // Requested reset cycles
    output logic            ext_reset_n,
    output logic            nmi_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    int n_cnt;                         // Cycles of NMI left
    int r_cnt;                         // Cycles of reset left
    // Both pins are plain levels with defined idle values, never released
    initial begin
        ext_reset_n = 1'b1;
        nmi_pin     = 1'b0;
        n_cnt       = 0;
        r_cnt       = 0;
    end
    // Pulses change just after the edge, like any real driver
    always @(posedge aclk) begin
        if (nmi_go) begin
            nmi_pin <= 1'b1;
            n_cnt   <= nmi_len;
        end else if (n_cnt > 1) begin
            n_cnt <= n_cnt - 1;
        end else begin
            nmi_pin <= 1'b0;
            n_cnt   <= 0;
        end
        // Short requests are stretched: reset must span the stabilisation time
        if (rst_go) begin
            ext_reset_n <= 1'b0;
            r_cnt       <= (rst_len > MIN_RST) ? rst_len : MIN_RST;
        end else if (r_cnt > 1) begin
            r_cnt <= r_cnt - 1;
        end else begin
            ext_reset_n <= 1'b1;
            r_cnt       <= 0;
        end
    end
endmodule : srrc_ext_src

// ---- bench/stop_release_and_reset_control_bench.sv ----
// ==========================================================
// Self-checking bench for the stop release and reset sequencer
module stop_release_and_reset_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import srrc_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1, ext_reset_n, nmi_pin;
    logic cpu_in_wdt_isr = 1'b0, cpu_in_nmi_isr = 1'b0, cpu_insn_done = 1'b0;
    logic cpu_return_from_irq = 1'b0, wdt_irq_req = 1'b0;
    logic [15:0] reset_vec_word = 16'h1234;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h1;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic osc_run, sys_clk_run, unit_reset, pins_hiz, pc_load, nmi_vector, wdt_vector;
    logic keep_ram_sp;
    logic [15:0] pc_value, wait_ctrl_reg, program_status_word, irq_mask_word;
    logic [7:0] async_serial_mode_reg, async_serial_status_reg, irq_mask_low, irq_mask_high;
    logic nmi_go = 1'b0, rst_go = 1'b0;
    logic [7:0] nmi_len = 8'h0c, rst_len = 8'h0a, lfsr = 8'h4a;  // Random source starts at 74
    logic [7:0] mode_exp = WDOG_RST;   // Watchdog mode value expected back
    logic [2:0] exp_q[$];              // Expected events {wdt, nmi, pc_load}
    int errors = 0;
    int n_checks = 0;
    // Short stabilisation count keeps wake-ups to a few cycles
    srrc_top #(.WDT_BITS(2)) srrc_top_inst (.aclk, .aresetn, .clk_en, .ext_reset_n, .nmi_pin,
        .cpu_in_wdt_isr, .cpu_in_nmi_isr, .cpu_insn_done, .cpu_return_from_irq, .wdt_irq_req,
        .reset_vec_word, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .osc_run, .sys_clk_run, .unit_reset, .pins_hiz, .pc_load,
        .pc_value, .nmi_vector, .wdt_vector, .keep_ram_sp, .wait_ctrl_reg, .program_status_word,
        .async_serial_mode_reg, .async_serial_status_reg, .irq_mask_low, .irq_mask_high,
        .irq_mask_word);
    srrc_ext_src #(.MIN_RST(8)) srrc_ext_src_inst (.aclk, .nmi_go, .nmi_len, .rst_go,
        .rst_len, .ext_reset_n, .nmi_pin);
    // ==========================================================
    // Clock and helpers
    always #10 aclk = ~aclk;
    function automatic logic [7:0] lfsr_next(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr_next
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : print_verdict
    // Address and data offered together, each dropped once taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        check("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        check("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
        check("rdata", s_axi_rdata, d);
    endtask : axi_rd
    // Bounded wait until every noted event has shown up
    task automatic wait_q(input string name);
        for (int k = 0; k < 300 && exp_q.size() != 0; k++) @(posedge aclk);
        check("events pending", exp_q.size(), 0);
        $display("test %s done", name);
    endtask : wait_q
    task automatic ret_then_insn;
        cpu_return_from_irq <= 1'b1;
        @(posedge aclk);
        cpu_return_from_irq <= 1'b0; cpu_insn_done <= 1'b1;
        @(posedge aclk);
        cpu_insn_done <= 1'b0;
    endtask : ret_then_insn
    // Stop with a given service context, then wake by NMI
    task automatic stop_nmi(input logic w, input logic n, input logic prio, input logic now_v);
        axi_wr(ADDR_WDOG, {27'h0, prio, 4'h0}, 2'b00);
        cpu_in_wdt_isr <= w; cpu_in_nmi_isr <= n;
        axi_wr(ADDR_STBY, 32'h0000_0002, 2'b00);
        repeat (2) @(posedge aclk);
        check("osc stopped", {31'h0, osc_run | sys_clk_run}, 0);
        nmi_go <= 1'b1; nmi_len <= 8'h0c;
        @(posedge aclk);
        nmi_go <= 1'b0;
        repeat (6) @(posedge aclk);
        check("clock held while nmi", {31'h0, sys_clk_run}, 0);
        if (now_v) exp_q.push_back(3'b010);
        repeat (30) @(posedge aclk);
        check("clock restarted", {31'h0, sys_clk_run}, 1);
        if (!now_v) exp_q.push_back(3'b010);
        if (!now_v) ret_then_insn;
        cpu_in_wdt_isr <= 1'b0; cpu_in_nmi_isr <= 1'b0;
        wait_q("stop wake");
    endtask : stop_nmi
    // ==========================================================
    // Monitor: every vector or load event is matched to the oldest note
    always @(posedge aclk) begin
        if (aresetn === 1'b1 && (pc_load | nmi_vector | wdt_vector) === 1'b1) begin
            if (pc_load === 1'b1) check("pc value", {16'h0, pc_value}, {16'h0, reset_vec_word});
            check("event", {29'h0, wdt_vector, nmi_vector, pc_load},
                {29'h0, (exp_q.size() != 0) ? exp_q.pop_front() : 3'b000});
        end
    end
    // Watchdog: the whole run is a few hundred cycles
    initial begin
        #200_000;
        errors++;
        print_verdict;
    end
    // ==========================================================
    // Main sequence
    initial begin
        repeat (20) @(posedge aclk);
        exp_q.push_back(3'b001);
        aresetn <= 1'b1;
        wait_q("reset release");
        check("unit reset off", {31'h0, unit_reset | pins_hiz}, 0);
        check("wait ctrl", {16'h0, wait_ctrl_reg}, {16'h0, WAIT_CTRL_RST});
        check("status word", {16'h0, program_status_word}, {16'h0, PSTAT_RST});
        check("serial", {async_serial_mode_reg, async_serial_status_reg}, 32'h0000_8000);
        check("masks", {irq_mask_word, irq_mask_high, irq_mask_low}, 32'hFFFF_FFFF);
        axi_rd(ADDR_CPU, {WAIT_CTRL_RST, PSTAT_RST}, 2'b00);
        axi_rd(8'h40, 32'h0000_0000, 2'b10);
        // Random watchdog mode writes, bit 3 always cleared, lane 0 strobe random
        for (int i = 0; i < 4; i++) begin
            lfsr = lfsr_next(lfsr);
            s_axi_wstrb <= {3'h0, lfsr[0]};
            if (lfsr[0]) mode_exp = lfsr & 8'hF7 & WDOG_WMASK;
            axi_wr(ADDR_WDOG, {24'h0, lfsr & 8'hF7}, 2'b00);
            axi_rd(ADDR_WDOG, {24'h0, mode_exp}, 2'b00);
        end
        s_axi_wstrb <= 4'h1;
        $display("test mode bits done");
        stop_nmi(1'b0, 1'b0, 1'b0, 1'b1);
        stop_nmi(1'b1, 1'b0, 1'b1, 1'b0);
        stop_nmi(1'b1, 1'b0, 1'b0, 1'b1);
        stop_nmi(1'b0, 1'b1, 1'b0, 1'b0);
        // Watchdog and NMI together, watchdog preferred
        axi_wr(ADDR_WDOG, 32'h0000_0010, 2'b00);
        exp_q.push_back(3'b010);
        exp_q.push_back(3'b100);
        // The pin rises one edge after the go strobe, so the request waits for it
        nmi_go <= 1'b1; nmi_len <= 8'h03;
        @(posedge aclk);
        nmi_go <= 1'b0; wdt_irq_req <= 1'b1;
        @(posedge aclk);
        wdt_irq_req <= 1'b0;
        repeat (3) @(posedge aclk);
        cpu_insn_done <= 1'b1;
        @(posedge aclk);
        cpu_insn_done <= 1'b0;
        wait_q("simultaneous");
        // Reset pin ends standby
        axi_wr(ADDR_STBY, 32'h0000_0002, 2'b00);
        repeat (2) @(posedge aclk);
        rst_go <= 1'b1; rst_len <= 8'h02; reset_vec_word <= {lfsr, ~lfsr};
        @(posedge aclk);
        rst_go <= 1'b0;
        repeat (3) @(posedge aclk);
        check("reset state", {29'h0, osc_run, unit_reset, pins_hiz}, 32'h0000_0007);
        // Enable low: reset stays held although the pin has gone high
        clk_en <= 1'b0;
        repeat (10) @(posedge aclk);
        check("frozen in reset", {31'h0, unit_reset}, 1);
        clk_en <= 1'b1;
        exp_q.push_back(3'b001);
        wait_q("reset from standby");
        check("keep ram", {31'h0, keep_ram_sp}, 1);
        print_verdict;
    end
endmodule : stop_release_and_reset_control_bench
